// file: rtl/fpu_sub_params.svh
// Purpose: constants of the floating-point subunit
// Assumes: included by the package, the host model and the bench
// Notes: offsets, field positions, reset values, codes
`ifndef FPU_SUB_PARAMS_SVH
`define FPU_SUB_PARAMS_SVH
// register byte offsets
`define OFS_CMD 12'h000
`define OFS_OPLO 12'h004
`define OFS_OPHI 12'h008
`define OFS_FLAGS 12'h00c
`define OFS_STATUS 12'h010
`define OFS_RESLO 12'h014
`define OFS_RESHI 12'h018
`define OFS_LORLO 12'h01c
`define OFS_LORHI 12'h020
// command register fields
`define CMD_OP_LSB 0
`define CMD_V1_LSB 8
`define CMD_V2_LSB 16
`define CMD_MODE_BIT 24
// flag bit positions
`define FLG_EXO 0
`define FLG_DVC 1
`define FLG_MPO 2
// operation and variant codes
`define OPC_SHIFT 6'h04
`define OPC_IMUL 6'h05
`define OPC_ACC 6'h06
`define OPC_MEM 6'h07
`define V2_STORE 6'h00
`define V2_LOADLOR 6'h01
`define V2_LOAD 6'h02
`define V2_STORELOR 6'h07
`define V2_ADD 6'h10
`define V2_SUB 6'h11
`define V2_MUL 6'h12
`define V2_DIV 6'h13
`define V2_TESTIND 6'h20
`define ACC_ZERO 3'h7
// widths and limits
`define MANT_W 36
`define EXP_W 12
`define WORD_W 48
`define EXP_MAX 14'sd2047
`define EXP_MIN (-14'sd2048)
`define EXP_WRAP 14'sd4096
`define IMUL_MAG 23
`define RST_WORD 48'h0
`define PUNCT_MASK 64'h3f3f3f3f3f3f3f3f
`endif

// file: rtl/fpu_sub_pkg.sv
// Purpose: types of the floating-point subunit
// Assumes: fpu_sub_params.svh defines widths
// Notes: holds types only
`include "fpu_sub_params.svh"
package fpu_sub_pkg;
  typedef struct packed {
    logic [`MANT_W-1:0] mant;
    logic [`EXP_W-1:0] expo;
  } fword_type;
  typedef struct packed {
    logic integer_multiply_overflow_flag;
    logic divide_check_flag;
    logic exponent_overflow_flag;
  } flags_type;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PREP = 4'b0010,
    ST_NORM = 4'b0100,
    ST_DONE = 4'b1000
  } state_type;
endpackage

// file: rtl/fpu_sub.sv
// Purpose: floating-point subunit behind an APB slave
// Assumes: pclk 200 MHz, presetn asynchronous active low
// Notes: one command runs per write of the command register
//
// Overview of operation
// - mantissa is 36-bit twos-complement fraction
// - exponent is 12-bit twos-complement integer
// - zero mantissa and exponent is normal zero
// - add, subtract, multiply and divide results normalized, top bits 01 or 10
// - four accumulators, codes 0 to 3
// - code 7 reads zero, writes discarded
// - low-order register extends precision 36 bits
// - exponent above 2047 flags, wraps by 4096
// - exponent below -2048 gives normal zero
// - zero divisor flags, skips, changes nothing
// - integer product over 23 bits flags overflow
// - flags cleared by test, reset, save
// - flags never raise an interrupt
// - operands other than a memory divisor accepted normalized or not
// - divisor in an accumulator prenormalized; unnormalized memory divisor flags divide check
// - dividend prenormalized only in subprocessor mode
// - equalize smaller exponent, bits into low register
// - postnormalize left, or one right on overflow
// - opcode 04 shift, opcode 05 integer multiply
// - opcodes 07 memory and 06 accumulator pair
// - variant upper bits source, lower destination
// - punctuation bits ignored, stored back as zero
// - word is 48 bits, mantissa on top
// - operand spans eight characters downward
`timescale 1ns/10ps
module fpu_sub #(
  parameter int ADDR_W = 12
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // indicator levels
  output fpu_sub_pkg::flags_type flags_out,
  output logic busy
);
  import fpu_sub_pkg::*;

  initial begin
    if (ADDR_W < 6) begin
      $error("ADDR_W too small for register map");
    end
  end

  // ************************************************************
  // helper functions
  // ************************************************************
  // a mantissa is normalized when its top two bits differ
  function automatic logic is_norm(input logic [`MANT_W-1:0] m);
    is_norm = m[`MANT_W-1] ^ m[`MANT_W-2];
  endfunction

  // mantissa is zero in either sign form only when all bits zero
  function automatic logic is_zero(input logic [`MANT_W-1:0] m);
    is_zero = (m == '0);
  endfunction

  // word out as eight characters, punctuation bits zero
  function automatic logic [63:0] to_chars(input logic [47:0] w);
    to_chars = '0;
    for (int i = 0; i < 8; i++) begin
      to_chars[8*i +: 6] = w[6*i +: 6];
    end
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  fword_type acc_ff [4];
  fword_type lor_ff, nxt_lor;
  flags_type flg_ff;
  state_type st_ff;
  logic [31:0] cmd_ff;
  logic [63:0] opnd_ff;
  logic [63:0] res_ff;
  logic [31:0] rdata_ff;
  logic ready_ff, err_ff;
  // working registers: signed mantissa/exponent with headroom
  logic signed [`MANT_W+1:0] wm_ff;
  logic signed [13:0] we_ff;
  logic [`MANT_W-1:0] wl_ff;
  logic [2:0] dst_ff;
  logic div_ff;

  // ************************************************************
  // command decode
  // ************************************************************
  wire [5:0] opc = cmd_ff[`CMD_OP_LSB +: 6];
  wire [5:0] v1 = cmd_ff[`CMD_V1_LSB +: 6];
  wire [5:0] v2 = cmd_ff[`CMD_V2_LSB +: 6];
  wire subproc = cmd_ff[`CMD_MODE_BIT];
  wire [2:0] src_sel = v1[5:3];
  wire [2:0] dst_sel = v1[2:0];

  // code 7 and unused codes read as normal zero
  function automatic fword_type rd_acc(input logic [2:0] s,
                                       input fword_type a0,
                                       input fword_type a1,
                                       input fword_type a2,
                                       input fword_type a3);
    case (s)
      3'd0: rd_acc = a0;
      3'd1: rd_acc = a1;
      3'd2: rd_acc = a2;
      3'd3: rd_acc = a3;
      default: rd_acc = `RST_WORD;
    endcase
  endfunction

  wire fword_type xw = rd_acc(src_sel, acc_ff[0], acc_ff[1],
                              acc_ff[2], acc_ff[3]);
  wire fword_type yw = rd_acc(dst_sel, acc_ff[0], acc_ff[1],
                              acc_ff[2], acc_ff[3]);
  // punctuation bits dropped, six data bits per character
  // character 7 is at the address, character 0 at A-7
  wire [47:0] mem_word = {opnd_ff[61:56], opnd_ff[53:48],
                          opnd_ff[45:40], opnd_ff[37:32],
                          opnd_ff[29:24], opnd_ff[21:16],
                          opnd_ff[13:8], opnd_ff[5:0]};
  // second operand from memory or from accumulator
  // mantissa upper 36 bits, exponent lower 12
  wire fword_type bw = (opc == `OPC_MEM) ? fword_type'(mem_word) : xw;

  // ************************************************************
  // operand alignment and arithmetic
  // ************************************************************
  // sign-extended fraction, sign-extended exponent
  wire signed [`MANT_W+1:0] am = {{2{yw.mant[35]}}, yw.mant};
  wire signed [`MANT_W+1:0] bm = {{2{bw.mant[35]}}, bw.mant};
  wire signed [13:0] ae = {{2{yw.expo[11]}}, yw.expo};
  wire signed [13:0] be = {{2{bw.expo[11]}}, bw.expo};
  wire a_big = (ae >= be);
  wire signed [13:0] ediff = a_big ? (ae - be) : (be - ae);
  // any gap beyond 63 places must saturate, not wrap in six bits
  wire [5:0] sh = (ediff > 14'sd63) ? 6'd63 : ediff[5:0];
  // smaller operand shifted right, spilled bits kept
  wire signed [2*`MANT_W+1:0] sm_ext =
    (a_big ? {bm, 36'h0} : {am, 36'h0}) >>> sh;
  wire signed [`MANT_W+1:0] big_m = a_big ? am : bm;
  wire signed [`MANT_W+1:0] small_m = sm_ext[2*`MANT_W+1:`MANT_W];
  wire signed [`MANT_W+1:0] sum_m = (v2 == `V2_SUB) ?
    (big_m - small_m) : (big_m + small_m);
  wire [`MANT_W-1:0] sum_l = sm_ext[`MANT_W-1:0];
  wire signed [13:0] sum_e = a_big ? ae : be;
  // product of fractions: drop the duplicated sign
  wire signed [2*`MANT_W+3:0] prod = am * bm;
  // quotient: dividend scaled down one place so it stays below 1
  wire signed [2*`MANT_W-1:0] dvd = {{2{am[35]}}, am[35:0], 34'h0};
  wire signed [2*`MANT_W-1:0] dsr = $signed({{34{bm[37]}}, bm});
  wire signed [2*`MANT_W-1:0] quo = (bm == 0) ? '0 : dvd / dsr;
  wire signed [2*`MANT_W-1:0] rem = (bm == 0) ? '0 : dvd % dsr;
  // integer multiply: 24-bit signed result window
  wire signed [2*`MANT_W+3:0] iprod = am * bm;
  // product beyond 23 magnitude bits plus sign
  wire imul_ovf = (iprod[2*`MANT_W+3:`IMUL_MAG] != '0) &&
                  (iprod[2*`MANT_W+3:`IMUL_MAG] != '1);

  // ************************************************************
  // normalization step
  // ************************************************************
  wire ovf_m = wm_ff[37] ^ wm_ff[35] || wm_ff[36] ^ wm_ff[35];
  wire zero_m = is_zero(wm_ff[35:0]);
  wire norm_m = is_norm(wm_ff[35:0]);

  // ************************************************************
  // apb decode
  // ************************************************************
  wire acc_ph = psel & penable & clk_en & ~ready_ff;
  wire wr_cmd = acc_ph & pwrite & (paddr == `OFS_CMD) & ~busy;
  wire wr_lo = acc_ph & pwrite & (paddr == `OFS_OPLO);
  wire wr_hi = acc_ph & pwrite & (paddr == `OFS_OPHI);
  wire wr_flg = acc_ph & pwrite & (paddr == `OFS_FLAGS);
  wire rd_flg = acc_ph & ~pwrite & (paddr == `OFS_FLAGS);
  wire known = (paddr <= `OFS_LORHI) && (paddr[1:0] == 2'b00);
  logic [31:0] rmux;
  always_comb begin
    case (paddr)
      `OFS_CMD: rmux = cmd_ff;
      `OFS_OPLO: rmux = opnd_ff[31:0];
      `OFS_OPHI: rmux = opnd_ff[63:32];
      `OFS_FLAGS: rmux = {29'h0, flg_ff};
      `OFS_STATUS: rmux = {31'h0, busy};
      `OFS_RESLO: rmux = res_ff[31:0];
      `OFS_RESHI: rmux = res_ff[63:32];
      `OFS_LORLO: rmux = lor_ff[31:0];
      `OFS_LORHI: rmux = {16'h0, lor_ff[47:32]};
      default: rmux = 32'h0;
    endcase
  end

  // apb answer: one wait state, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else if (clk_en) begin
      ready_ff <= acc_ph;
      err_ff <= acc_ph & (~known | (wr_cmd == 1'b0 & pwrite &
                (paddr == `OFS_CMD)));
      if (acc_ph & ~pwrite) begin
        rdata_ff <= rmux;
      end
    end
  end

  // ************************************************************
  // execution state machine
  // ************************************************************
  logic [`WORD_W-1:0] res_word;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE;
      cmd_ff <= 32'h0;
      opnd_ff <= 64'h0;
      res_ff <= 64'h0;
      wm_ff <= '0;
      we_ff <= '0;
      wl_ff <= '0;
      dst_ff <= 3'h0;
      div_ff <= 1'b0;
      lor_ff <= `RST_WORD;
      flg_ff <= '0;
      for (int i = 0; i < 4; i++) begin
        acc_ff[i] <= `RST_WORD;
      end
    end else if (clk_en) begin
      if (wr_cmd) begin
        cmd_ff <= pwdata;
      end
      if (wr_lo) begin
        opnd_ff[31:0] <= pwdata;
      end
      if (wr_hi) begin
        opnd_ff[63:32] <= pwdata;
      end
      // restore writes flags, save reads and clears
      if (wr_flg) begin
        flg_ff <= flags_type'(pwdata[2:0]);
      end else if (rd_flg) begin
        flg_ff <= '0;
      end
      case (st_ff)
        ST_IDLE: begin
          if (wr_cmd) begin
            st_ff <= ST_PREP;
          end
        end
        ST_PREP: begin
          dst_ff <= dst_sel;
          div_ff <= 1'b0;
          st_ff <= ST_DONE;
          // opcode 04 shift, 05 integer multiply
          if (opc == `OPC_SHIFT) begin
            wm_ff <= am <<< v2[5:0];
            we_ff <= ae;
            st_ff <= ST_NORM;
            div_ff <= 1'b1;
          end else if (opc == `OPC_IMUL) begin
            if (imul_ovf) begin
              flg_ff.integer_multiply_overflow_flag <= 1'b1;
            end
            if (dst_sel != `ACC_ZERO) begin
              acc_ff[dst_sel[1:0]] <= {12'h0, iprod[23:0], ae[11:0]};
            end
          end else if (opc == `OPC_MEM || opc == `OPC_ACC) begin
            case (v2)
              `V2_STORE: begin
                res_ff <= to_chars(xw);
                if (opc == `OPC_ACC && dst_sel != `ACC_ZERO) begin
                  acc_ff[dst_sel[1:0]] <= xw;
                end
              end
              `V2_LOAD: begin
                // results aimed at code 7 vanish
                if (dst_sel != `ACC_ZERO) begin
                  acc_ff[dst_sel[1:0]] <= bw;
                end
              end
              `V2_LOADLOR: lor_ff <= bw;
              `V2_STORELOR: begin
                res_ff <= to_chars(lor_ff);
                if (opc == `OPC_ACC && dst_sel != `ACC_ZERO) begin
                  acc_ff[dst_sel[1:0]] <= lor_ff;
                end
              end
              `V2_TESTIND: begin
                res_ff <= {61'h0, flg_ff};
                flg_ff <= '0;
              end
              `V2_ADD, `V2_SUB: begin
                wm_ff <= sum_m;
                wl_ff <= sum_l;
                we_ff <= sum_e;
                st_ff <= ST_NORM;
              end
              `V2_MUL: begin
                wm_ff <= prod[71:34];
                wl_ff <= {prod[33:0], 2'b00};
                we_ff <= ae + be;
                st_ff <= ST_NORM;
              end
              `V2_DIV: begin
                if (is_zero(bw.mant)) begin
                  flg_ff.divide_check_flag <= 1'b1;
                end else if (!is_norm(bw.mant) ||
                             (subproc && !is_norm(yw.mant))) begin
                  if (!is_norm(bw.mant)) begin
                    opnd_ff[63:0] <= 64'h0;
                  end
                  st_ff <= ST_PREP;
                  if (!is_norm(bw.mant) && opc == `OPC_ACC &&
                      src_sel[2] == 1'b0) begin
                    acc_ff[src_sel[1:0]] <=
                      {bw.mant << 1, bw.expo - 12'h1};
                  end else if (!is_norm(bw.mant)) begin
                    cmd_ff[`CMD_OP_LSB +: 6] <= `OPC_ACC;
                    cmd_ff[`CMD_V1_LSB +: 3] <= 3'h7;
                    st_ff <= ST_DONE;
                    flg_ff.divide_check_flag <= 1'b1;
                  end else if (dst_sel[2] == 1'b0) begin
                    acc_ff[dst_sel[1:0]] <=
                      {yw.mant << 1, yw.expo - 12'h1};
                  end
                end else begin
                  // quotient is half the true ratio, exponent plus one
                  wm_ff <= {{2{quo[35]}}, quo[35:0]};
                  wl_ff <= rem[35:0];
                  we_ff <= ae - be + 14'sd1;
                  st_ff <= ST_NORM;
                end
              end
              default: ;
            endcase
          end
        end
        ST_NORM: begin
          // overflow shifts right once, else left
          if (ovf_m && !div_ff) begin
            wm_ff <= wm_ff >>> 1;
            we_ff <= we_ff + 14'sd1;
          end else if (!norm_m && !zero_m && !div_ff) begin
            wm_ff <= {wm_ff[36:0], wl_ff[35]};
            wl_ff <= wl_ff << 1;
            we_ff <= we_ff - 14'sd1;
          end else begin
            st_ff <= ST_DONE;
            if (dst_ff != `ACC_ZERO) begin
              acc_ff[dst_ff[1:0]] <= res_word;
            end
            lor_ff <= {wl_ff, 12'h0};
            if (we_ff > `EXP_MAX && !zero_m) begin
              flg_ff.exponent_overflow_flag <= 1'b1;
            end
          end
        end
        ST_DONE: st_ff <= ST_IDLE;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // zero mantissa or underflow gives normal zero
  // wrap exponent by 4096 on overflow
  wire signed [13:0] wrap_e = (we_ff > `EXP_MAX) ?
    (we_ff - `EXP_WRAP) : we_ff;
  assign res_word = (zero_m || we_ff < `EXP_MIN) ? `RST_WORD :
    {wm_ff[35:0], wrap_e[11:0]};

  // ************************************************************
  // outputs
  // ************************************************************
  // flags leave as plain levels, no interrupt line
  assign prdata = rdata_ff;
  assign pready = ready_ff;
  assign pslverr = err_ff;
  assign flags_out = flg_ff;
  assign busy = (st_ff != ST_IDLE);

  // ************************************************************
  // assertions
  // ************************************************************
  sequence div_zero_s;
    clk_en && st_ff == ST_PREP &&
      (opc == `OPC_MEM || opc == `OPC_ACC) &&
      v2 == `V2_DIV && is_zero(bw.mant);
  endsequence

  div_check_a: assert property (@(posedge pclk) disable iff (!presetn)
    div_zero_s |=> flg_ff.divide_check_flag && $stable(acc_ff[0]))
    else $error("divide check not flagged");

  zero_pseudo_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc(3'd7, acc_ff[0], acc_ff[1], acc_ff[2], acc_ff[3]) == 0)
    else $error("pseudo accumulator not zero");

  norm_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff == ST_NORM && clk_en && !ovf_m && !zero_m && !div_ff &&
      norm_m |-> res_word == 0 || is_norm(res_word[47:12]))
    else $error("result not normalized");

  test_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && st_ff == ST_PREP && v2 == `V2_TESTIND &&
      opc == `OPC_MEM && !wr_flg |=> flg_ff == 0)
    else $error("indicators not cleared by test");

  underflow_a: assert property (@(posedge pclk) disable iff (!presetn)
    we_ff < `EXP_MIN |-> res_word == 0)
    else $error("underflow not zero");

  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc_ph |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  mpo_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && st_ff == ST_PREP && opc == `OPC_IMUL && imul_ovf
      |=> flg_ff.integer_multiply_overflow_flag)
    else $error("multiply overflow not flagged");

  busy_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmd |=> busy)
    else $error("command did not start");
endmodule

// file: sim/host_path_model.sv
// Purpose: host side of the subunit, an apb master
// Assumes: pclk rising edge, one transfer at a time
// Notes: released lines carry inverted values
`timescale 1ns/10ps
`include "fpu_sub_params.svh"
module host_path_model (
  // clock
  input wire logic pclk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // one transfer; the leading edge keeps back-to-back calls apart
  task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look mid-cycle at the registered answer, complete on next rise
    do begin
      @(negedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  function automatic logic [63:0] pack(input logic [47:0] w,
      input logic [1:0] p);
    logic [63:0] v;
    for (int i = 0; i < 8; i++) begin
      v[8*i +: 8] = {p, w[6*i +: 6]};
    end
    return v;
  endfunction

  task automatic command(input logic [5:0] op, v1, v2);
    logic [31:0] q;
    logic e;
    xfer(1'b1, `OFS_CMD, {8'h01, 2'h0, v2, 2'h0, v1, 2'h0, op}, q, e);
    do begin
      xfer(1'b0, `OFS_STATUS, 32'h0, q, e);
    end while (q[0] !== 1'b0);
  endtask
endmodule

// file: sim/fpu_sub_bench.sv
// Purpose: self-checking bench of the floating-point subunit
// Assumes: host_path_model drives every apb transfer
// Notes: subprocessor mode is used for all commands
`timescale 1ns/10ps
`include "fpu_sub_params.svh"
module fpu_sub_bench;
  import fpu_sub_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite;
  logic pready, pslverr, busy, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  flags_type flags_out;
  int n_errors = 0;
  int check_count = 0;

  fpu_sub #(.ADDR_W(12)) fpu_sub_i (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flags_out(flags_out), .busy(busy));
  host_path_model host_path_model_i (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 200 mhz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic check(input logic [63:0] seen, exp, input string m);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t %s seen %h want %h", $time, m, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // *****************************************
  // bus and accumulator helpers
  // *****************************************
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_path_model_i.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rdr(input logic [11:0] a);
    host_path_model_i.xfer(1'b0, a, 32'h0, rd, er);
  endtask
  // punctuation set on the way in, must not leak into the word
  task automatic put_op(input logic [47:0] w);
    logic [63:0] v;
    v = host_path_model_i.pack(w, 2'b11);
    wr(`OFS_OPLO, v[31:0]);
    wr(`OFS_OPHI, v[63:32]);
  endtask
  task automatic load(input logic [2:0] y, input logic [47:0] w);
    put_op(w);
    host_path_model_i.command(`OPC_MEM, {3'h0, y}, `V2_LOAD);
  endtask
  task automatic op2(input logic [2:0] x, y, input logic [5:0] v2);
    host_path_model_i.command(`OPC_ACC, {x, y}, v2);
  endtask
  task automatic expect_acc(input logic [2:0] x, input logic [47:0] w);
    logic [63:0] v;
    host_path_model_i.command(`OPC_MEM, {x, 3'h0}, `V2_STORE);
    rdr(`OFS_RESLO);
    v[31:0] = rd;
    rdr(`OFS_RESHI);
    v[63:32] = rd;
    check(v, host_path_model_i.pack(w, 2'b00), "stored word");
  endtask

  // *****************************************
  // scenarios
  // *****************************************
  task automatic t_reset();
    check(flags_out, 3'h0, "flags after reset");
    rdr(`OFS_FLAGS);
    check(rd, 32'h0, "saved flags after reset");
    expect_acc(3'h2, 48'h0);
    rdr(12'hffc);
    check({er, rd}, {1'b1, 32'h0}, "unmapped read");
  endtask

  task automatic t_accs();
    for (int i = 0; i < 4; i++) begin
      load(3'(i), {36'h9_abcd_ef01 + 36'(i), 12'h5a0 + 12'(i)});
    end
    for (int i = 0; i < 4; i++) begin
      expect_acc(3'(i), {36'h9_abcd_ef01 + 36'(i), 12'h5a0 + 12'(i)});
    end
    load(3'h7, 48'h1234_5678_9abc);
    expect_acc(3'h7, 48'h0);
  endtask

  // adding the zero pseudo accumulator normalizes acc 0
  task automatic t_norm();
    logic [47:0] ins [3] = '{48'h2_0000_0000_000, 48'he_8000_0000_000,
      48'h2_0000_0000_800};
    logic [47:0] outs [3] = '{48'h4_0000_0000_fff, 48'ha_0000_0000_ffe,
      48'h0};
    for (int i = 0; i < 3; i++) begin
      load(3'h0, ins[i]);
      op2(3'h7, 3'h0, `V2_ADD);
      expect_acc(3'h0, outs[i]);
    end
  endtask

  task automatic t_exo();
    load(3'h0, 48'h4_0000_0000_7ff);
    op2(3'h0, 3'h0, `V2_ADD);
    expect_acc(3'h0, 48'h4_0000_0000_800);
    check(flags_out, 3'b001, "overflow flag");
    rdr(`OFS_FLAGS);
    check(rd[2:0], 3'b001, "saved flags");
    check(flags_out, 3'b000, "flags after save");
  endtask

  task automatic t_lor();
    load(3'h0, 48'h4_0000_0000_001);
    load(3'h1, 48'h4_0000_0001_000);
    op2(3'h1, 3'h0, `V2_ADD);
    expect_acc(3'h0, 48'h6_0000_0000_001);
    rdr(`OFS_LORHI);
    check(rd[15], 1'b1, "shifted bit in low register");
    put_op(48'hc_3a5a_0f0f_123);
    host_path_model_i.command(`OPC_MEM, 6'h00, `V2_LOADLOR);
    rdr(`OFS_LORLO);
    check(rd, 32'ha0f0_f123, "low register low");
    rdr(`OFS_LORHI);
    check(rd[15:0], 16'hc3a5, "low register high");
    op2(3'h0, 3'h3, `V2_STORELOR);
    expect_acc(3'h3, 48'hc_3a5a_0f0f_123);
  endtask

  task automatic t_div();
    load(3'h1, 48'h0);
    load(3'h0, 48'h4_0000_0000_003);
    op2(3'h1, 3'h0, `V2_DIV);
    check(flags_out, 3'b010, "divide check");
    expect_acc(3'h0, 48'h4_0000_0000_003);
    host_path_model_i.command(`OPC_MEM, 6'h00, `V2_TESTIND);
    check(flags_out, 3'b000, "flags after test");
    load(3'h1, 48'h2_0000_0000_001);
    load(3'h0, 48'h2_0000_0000_001);
    op2(3'h1, 3'h0, `V2_DIV);
    expect_acc(3'h0, 48'h4_0000_0000_001);
    wr(`OFS_FLAGS, 32'h6);
    check(flags_out, 3'b110, "restored flags");
    rdr(`OFS_FLAGS);
    check(rd[2:0], 3'b110, "saved restored flags");
    check(flags_out, 3'b000, "flags cleared by save");
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_accs();
    t_norm();
    t_exo();
    t_lor();
    t_div();
    test_done();
  end

  // watchdog at 40000 cycles, far beyond the several hundred cycles the run needs
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
endmodule
